// [core/list_seq_pkg.sv]
// constants shared by the list sequencer core and its dwell timer
// assumes a 200 MHz aclk and an AXI4-Lite master with 32-bit data
package list_seq_pkg;
  // bus geometry and responses
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL         = 8'h00; // clear, run, direction, mode, output
  localparam logic [7:0] OFS_LEVEL_LOAD   = 8'h04; // append one level
  localparam logic [7:0] OFS_DWELL_LOAD   = 8'h08; // append one dwell, in timebase ticks
  localparam logic [7:0] OFS_REPEAT_COUNT = 8'h0C;
  localparam logic [7:0] OFS_LEADING_SKIP = 8'h10;
  localparam logic [7:0] OFS_LEVEL_POINTS = 8'h14; // read only
  localparam logic [7:0] OFS_DWELL_POINTS = 8'h18; // read only
  localparam logic [7:0] OFS_STATUS       = 8'h1C; // read only
  localparam logic [7:0] OFS_PASSES_LEFT  = 8'h20; // read only

  // control word bit positions
  localparam int CTRL_CLEAR  = 0;
  localparam int CTRL_RUN    = 1;
  localparam int CTRL_DOWN   = 2;
  localparam int CTRL_VOLT   = 3;
  localparam int CTRL_OUT_ON = 4;

  // table geometry
  localparam int LEVEL_W     = 16;
  localparam int DWELL_W     = 15;
  localparam int COUNT_W     = 16;
  localparam int SKIP_W      = 8;
  localparam int PTR_W       = 10;
  localparam int TABLE_DEPTH = 1002;

  // dwell range in ticks of 0.5 ms: 0.0005 s to 10 s
  localparam logic [DWELL_W-1:0] DWELL_MIN = 15'h0001;
  localparam logic [DWELL_W-1:0] DWELL_MAX = 15'h4E20;

  // timebase
  localparam int TICK_NS          = 500000;
  localparam int CLK_PERIOD_NS    = 5;
  localparam int TICK_CYCLES_DEF  = TICK_NS / CLK_PERIOD_NS;

  // values after reset
  localparam logic RST_DOWN = 1'b0;
  localparam logic RST_VOLT = 1'b1;
  localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0001;
endpackage

// [core/dwell_timer.sv]
// dwell timer: counts a fixed timebase, then counts ticks of one step
// assumes load, ticks and abort come from logic on the same aclk
`timescale 1ns/1ps
module dwell_timer #(
  parameter int TICK_CYCLES = list_seq_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             load,
  input  wire logic [list_seq_pkg::DWELL_W-1:0] ticks,
  input  wire logic                             abort,
  output logic                                  expire
);
  import list_seq_pkg::*;
  localparam int CYC_W = $clog2(TICK_CYCLES) + 1;

  logic [CYC_W-1:0]   cyc_reg,    cyc_next;
  logic [DWELL_W-1:0] tk_reg,     tk_next;
  logic               active_reg, active_next;

  // last cycle of the last tick of the step
  assign expire = active_reg && (cyc_reg == '0) && (tk_reg == '0);

  // count down cycles inside a tick, then ticks inside the step
  always_comb begin
    cyc_next    = cyc_reg;
    tk_next     = tk_reg;
    active_next = active_reg;
    if (active_reg) begin
      if (cyc_reg != '0) begin
        cyc_next = cyc_reg - 1'b1;
      end else if (tk_reg != '0) begin
        tk_next  = tk_reg - 1'b1;
        cyc_next = CYC_W'(TICK_CYCLES - 1);
      end else begin
        active_next = 1'b0;
      end
    end
    if (load) begin
      cyc_next    = CYC_W'(TICK_CYCLES - 1);
      tk_next     = (ticks == '0) ? '0 : ticks - 1'b1;
      active_next = 1'b1;
    end
    if (abort) begin
      active_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_reg    <= '0;
      tk_reg     <= '0;
      active_reg <= 1'b0;
    end else begin
      cyc_reg    <= cyc_next;
      tk_reg     <= tk_next;
      active_reg <= active_next;
    end
  end
endmodule

// [core/list_sequencer.sv]
// list sequencer core with an AXI4-Lite register slave
// assumes one aclk domain and a host that programs the tables before a run
//
// Summary of operation
// - clear returns every list pointer to zero
// - clear empties level, dwell tables; ready again
// - levels fill from location zero in order
// - later loads append after existing entries
// - level points read gives stored entry count
// - single dwell entry applies to every step
// - voltage mode makes the table hold voltages
// - run command plays levels for their dwells
// - last step goes straight to first step
// - no idle cycles between steps or passes
// - after final pass stop, hold last level
// - down runs highest location to zero
// - down run ends holding location zero
// - skip leading steps after the first pass
// - skip only applies in up direction
// - dwell accepted from 0.5 ms to 10 s
// - level table holds at most 1002 entries
// - reset and clear set direction up
`timescale 1ns/1ps
module list_sequencer #(
  parameter int TICK_CYCLES = list_seq_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [list_seq_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [list_seq_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  input  wire logic [list_seq_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [list_seq_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready,
  output logic [list_seq_pkg::LEVEL_W-1:0]      setpoint,
  output logic                                  output_on,
  output logic                                  running
);
  import list_seq_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // tables
  logic [LEVEL_W-1:0] level_mem [TABLE_DEPTH];
  logic [DWELL_W-1:0] dwell_mem [TABLE_DEPTH];

  // bus state
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              bvalid_reg,  bvalid_next,  arready_reg, arready_next;
  logic              rvalid_reg,  rvalid_next;
  logic [1:0]        bresp_reg,   bresp_next,   rresp_reg,  rresp_next;
  logic [ADDR_W-1:0] waddr_reg,   waddr_next;
  logic [DATA_W-1:0] wdat_reg,    wdat_next,    rdata_reg,  rdata_next;
  logic [3:0]        wstrb_reg,   wstrb_next;
  // configuration state
  logic [PTR_W-1:0]   level_ptr_reg, level_ptr_next, dwell_ptr_reg, dwell_ptr_next;
  logic [COUNT_W-1:0] count_reg,     count_next;
  logic [SKIP_W-1:0]  skip_reg,      skip_next;
  logic               down_reg,      down_next,  volt_reg, volt_next;
  logic               out_on_reg,    out_on_next;
  // sequencer state
  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;
  seq_state_t         state_reg,     state_next;
  logic [PTR_W-1:0]   idx_reg,       idx_next,   load_idx;
  logic [COUNT_W-1:0] pass_reg,      pass_next;
  logic [LEVEL_W-1:0] setpoint_reg,  setpoint_next;
  // decoded strobes
  logic               wr_fire, clear_cmd, start_cmd, ctrl_wr, level_wr, dwell_wr;
  logic               last_step, step_load, expire, running_now;
  logic [DWELL_W-1:0] load_ticks;
  logic [1:0]         wr_resp;

  assign running_now = (state_reg == ST_RUN);

  // write decode, performed once both address and data are held
  always_comb begin
    wr_fire   = !awready_reg && !wready_reg && !bvalid_reg;
    ctrl_wr   = wr_fire && hit(waddr_reg, OFS_CTRL) && (wstrb_reg[0] == 1'b1);
    clear_cmd = ctrl_wr && wdat_reg[CTRL_CLEAR];
    start_cmd = ctrl_wr && wdat_reg[CTRL_RUN] && !wdat_reg[CTRL_CLEAR];
    level_wr  = wr_fire && hit(waddr_reg, OFS_LEVEL_LOAD) && !running_now
                && volt_reg && (level_ptr_reg < PTR_W'(TABLE_DEPTH));
    dwell_wr  = wr_fire && hit(waddr_reg, OFS_DWELL_LOAD) && !running_now
                && (dwell_ptr_reg < PTR_W'(TABLE_DEPTH))
                && (wdat_reg[DWELL_W-1:0] >= DWELL_MIN)
                && (wdat_reg[DWELL_W-1:0] <= DWELL_MAX)
                && (wdat_reg[DATA_W-1:DWELL_W] == '0);
    wr_resp   = RESP_OKAY;
    if (hit(waddr_reg, OFS_LEVEL_LOAD)) begin
      wr_resp = level_wr ? RESP_OKAY : RESP_SLVERR;
    end else if (hit(waddr_reg, OFS_DWELL_LOAD)) begin
      wr_resp = dwell_wr ? RESP_OKAY : RESP_SLVERR;
    end else if (!hit(waddr_reg, OFS_CTRL) && !hit(waddr_reg, OFS_REPEAT_COUNT)
                 && !hit(waddr_reg, OFS_LEADING_SKIP)) begin
      wr_resp = RESP_SLVERR;
    end
  end

  // write channels: take address and data in either order, then answer
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    waddr_next   = waddr_reg;
    wdat_next    = wdat_reg;
    wstrb_next   = wstrb_reg;
    if (awvalid && awready_reg) begin
      awready_next = 1'b0;
      waddr_next   = awaddr;
    end
    if (wvalid && wready_reg) begin
      wready_next = 1'b0;
      wdat_next   = wdata;
      wstrb_next  = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end else if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next  = wr_resp;
    end
  end

  // read channel: one cycle from address to data
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = '0;
      if (hit(araddr, OFS_CTRL)) begin
        rdata_next[CTRL_DOWN]   = down_reg;
        rdata_next[CTRL_VOLT]   = volt_reg;
        rdata_next[CTRL_OUT_ON] = out_on_reg;
      end else if (hit(araddr, OFS_REPEAT_COUNT)) begin
        rdata_next[COUNT_W-1:0] = count_reg;
      end else if (hit(araddr, OFS_LEADING_SKIP)) begin
        rdata_next[SKIP_W-1:0] = skip_reg;
      end else if (hit(araddr, OFS_LEVEL_POINTS)) begin
        rdata_next[PTR_W-1:0] = level_ptr_reg;
      end else if (hit(araddr, OFS_DWELL_POINTS)) begin
        rdata_next[PTR_W-1:0] = dwell_ptr_reg;
      end else if (hit(araddr, OFS_STATUS)) begin
        rdata_next[0]                  = running_now;
        rdata_next[DATA_W-1:LEVEL_W]   = setpoint_reg;
      end else if (hit(araddr, OFS_PASSES_LEFT)) begin
        rdata_next[COUNT_W-1:0] = pass_reg;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  // configuration and table pointers
  always_comb begin
    level_ptr_next = level_ptr_reg;
    dwell_ptr_next = dwell_ptr_reg;
    count_next     = count_reg;
    skip_next      = skip_reg;
    down_next      = down_reg;
    volt_next      = volt_reg;
    out_on_next    = out_on_reg;
    if (level_wr) begin
      level_ptr_next = level_ptr_reg + 1'b1;
    end
    if (dwell_wr) begin
      dwell_ptr_next = dwell_ptr_reg + 1'b1;
    end
    if (ctrl_wr) begin
      out_on_next = wdat_reg[CTRL_OUT_ON];
      if (!running_now) begin
        down_next = wdat_reg[CTRL_DOWN];
        volt_next = wdat_reg[CTRL_VOLT];
      end
    end
    if (wr_fire && !running_now && hit(waddr_reg, OFS_REPEAT_COUNT)) begin
      count_next = wdat_reg[COUNT_W-1:0];
    end
    if (wr_fire && !running_now && hit(waddr_reg, OFS_LEADING_SKIP)) begin
      skip_next = wdat_reg[SKIP_W-1:0];
    end
    if (clear_cmd) begin
      level_ptr_next = '0;
      dwell_ptr_next = '0;
      skip_next      = '0;
      down_next      = 1'b0;
    end
  end

  // dwell for a step: one entry covers all, short table reuses its last entry
  always_comb begin
    if (dwell_ptr_reg == '0) begin
      load_ticks = DWELL_MIN;
    end else if (dwell_ptr_reg == PTR_W'(1)) begin
      load_ticks = dwell_mem[0];
    end else if (load_idx < dwell_ptr_reg) begin
      load_ticks = dwell_mem[load_idx];
    end else begin
      load_ticks = dwell_mem[dwell_ptr_reg - 1'b1];
    end
  end

  // step sequencing
  always_comb begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    pass_next     = pass_reg;
    setpoint_next = setpoint_reg;
    step_load     = 1'b0;
    load_idx      = idx_reg;
    last_step     = down_reg ? (idx_reg == '0) : (idx_reg == level_ptr_reg - 1'b1);
    if (clear_cmd) begin
      state_next = ST_IDLE;
    end else if (start_cmd && !running_now && volt_reg && level_ptr_reg != '0) begin
      state_next = ST_RUN;
      pass_next  = (count_reg == '0) ? COUNT_W'(1) : count_reg;
      load_idx   = down_reg ? level_ptr_reg - 1'b1 : '0;
      step_load  = 1'b1;
    end else if (running_now && expire) begin
      if (!last_step) begin
        load_idx  = down_reg ? idx_reg - 1'b1 : idx_reg + 1'b1;
        step_load = 1'b1;
      end else if (pass_reg == COUNT_W'(1)) begin
        state_next = ST_IDLE;
      end else begin
        pass_next = pass_reg - 1'b1;
        if (down_reg) begin
          load_idx = level_ptr_reg - 1'b1;
        end else if (PTR_W'(skip_reg) < level_ptr_reg) begin
          load_idx = PTR_W'(skip_reg);
        end else begin
          load_idx = '0;
        end
        step_load = 1'b1;
      end
    end
    if (step_load) begin
      idx_next      = load_idx;
      setpoint_next = level_mem[load_idx];
    end
  end

  dwell_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (step_load),
    .ticks   (load_ticks),
    .abort   (clear_cmd),
    .expire  (expire)
  );

  // tables are written at the fill pointer
  always_ff @(posedge aclk) begin
    if (level_wr) begin
      level_mem[level_ptr_reg] <= wdat_reg[LEVEL_W-1:0];
    end
    if (dwell_wr) begin
      dwell_mem[dwell_ptr_reg] <= wdat_reg[DWELL_W-1:0];
    end
  end

  // register stage for all control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;       wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;       bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;       rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;  rdata_reg   <= '0;
      waddr_reg   <= '0;         wdat_reg    <= '0;
      wstrb_reg   <= '0;         level_ptr_reg <= '0;
      dwell_ptr_reg <= '0;       count_reg   <= RST_COUNT;
      skip_reg    <= '0;         down_reg    <= RST_DOWN;
      volt_reg    <= RST_VOLT;   out_on_reg  <= 1'b0;
      state_reg   <= ST_IDLE;    idx_reg     <= '0;
      pass_reg    <= '0;         setpoint_reg <= '0;
    end else begin
      awready_reg <= awready_next;  wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;   bresp_reg   <= bresp_next;
      arready_reg <= arready_next;  rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;    rdata_reg   <= rdata_next;
      waddr_reg   <= waddr_next;    wdat_reg    <= wdat_next;
      wstrb_reg   <= wstrb_next;    level_ptr_reg <= level_ptr_next;
      dwell_ptr_reg <= dwell_ptr_next; count_reg <= count_next;
      skip_reg    <= skip_next;     down_reg    <= down_next;
      volt_reg    <= volt_next;     out_on_reg  <= out_on_next;
      state_reg   <= state_next;    idx_reg     <= idx_next;
      pass_reg    <= pass_next;     setpoint_reg <= setpoint_next;
    end
  end

  // port drive, all from flip-flops
  assign awready   = awready_reg;
  assign wready    = wready_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = arready_reg;
  assign rvalid    = rvalid_reg;
  assign rresp     = rresp_reg;
  assign rdata     = rdata_reg;
  assign setpoint  = setpoint_reg;
  assign output_on = out_on_reg;
  assign running   = (state_reg == ST_RUN);

  // checks on the sequencer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_final_expire;
    running_now && expire && last_step && (pass_reg == COUNT_W'(1));
  endsequence
  sequence s_wrap;
    running_now && expire && last_step && (pass_reg != COUNT_W'(1)) && !clear_cmd;
  endsequence

  AST_CLEAR_PTRS: assert property (clear_cmd |=> (level_ptr_reg == '0) &&
    (dwell_ptr_reg == '0) && (skip_reg == '0) && !down_reg && !running_now)
    else $error("clear left pointers, skip or direction set");
  AST_APPEND: assert property (level_wr |=> level_ptr_reg == $past(level_ptr_reg) + 1'b1)
    else $error("level load did not advance the fill pointer");
  AST_POINTS: assert property ((arvalid && arready_reg && hit(araddr, OFS_LEVEL_POINTS))
    |=> rvalid_reg && (rdata_reg == DATA_W'($past(level_ptr_reg))))
    else $error("level points read does not match the fill pointer");
  AST_NO_GAP: assert property ((running_now && expire && !clear_cmd
    && !(last_step && (pass_reg == COUNT_W'(1)))) |-> step_load)
    else $error("step ended without the next step loading");
  // a new run may legally start right after the end, so only idle cycles must hold the level
  AST_HOLD: assert property (s_final_expire ##0 !clear_cmd
    |=> (!running_now && $stable(setpoint_reg))
    ##1 (running_now || $stable(setpoint_reg))[*3])
    else $error("output moved after the final pass");
  AST_DOWN_END: assert property ((s_final_expire ##0 down_reg) |-> idx_reg == '0)
    else $error("down run ended away from location zero");
  AST_SKIP_WRAP: assert property ((s_wrap ##0 !down_reg ##0 (PTR_W'(skip_reg) < level_ptr_reg))
    |=> idx_reg == PTR_W'($past(skip_reg))) else $error("wrap ignored the skip count");
  AST_DOWN_WRAP: assert property ((s_wrap ##0 down_reg)
    |=> idx_reg == $past(level_ptr_reg) - 1'b1) else $error("down wrap not at top");
  AST_DWELL_RANGE: assert property ((wr_fire && hit(waddr_reg, OFS_DWELL_LOAD)
    && ((wdat_reg[DWELL_W-1:0] < DWELL_MIN) || (wdat_reg[DWELL_W-1:0] > DWELL_MAX)))
    |=> bvalid_reg && (bresp_reg == RESP_SLVERR)
    && (dwell_ptr_reg == $past(dwell_ptr_reg)))
    else $error("dwell out of range stored");
  AST_DEPTH: assert property (level_ptr_reg <= PTR_W'(TABLE_DEPTH))
    else $error("level table grew past its depth");
endmodule

// [bench/list_host.sv]
// host model: programs the sequencer over the register bus, one write and one read at a time
// assumes a single aclk shared with the sequencer and an answer within 50 cycles
`timescale 1ns/1ps
module list_host (
  input  wire logic                            aclk,
  output logic [list_seq_pkg::ADDR_W-1:0]      awaddr,
  output logic                                 awvalid,
  input  wire logic                            awready,
  output logic [list_seq_pkg::DATA_W-1:0]      wdata,
  output logic [3:0]                           wstrb,
  output logic                                 wvalid,
  input  wire logic                            wready,
  input  wire logic [1:0]                      bresp,
  input  wire logic                            bvalid,
  output logic                                 bready,
  output logic [list_seq_pkg::ADDR_W-1:0]      araddr,
  output logic                                 arvalid,
  input  wire logic                            arready,
  input  wire logic [list_seq_pkg::DATA_W-1:0] rdata,
  input  wire logic [1:0]                      rresp,
  input  wire logic                            rvalid,
  output logic                                 rready,
  output logic                                 hung
);
  import list_seq_pkg::*;
  // bus idle from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
    wstrb = 4'hF;
  end
  // write: address and data offered together, each released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) r = bresp;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) hung <= 1'b1; // no answer: bench ends the run
  endtask
  // read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    d = 32'hFFFF_FFFF;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
      end
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) hung <= 1'b1;
  endtask
endmodule

// [bench/list_waveform_sequencer_bench.sv]
// bench for the list sequencer: programs tables through the host model, checks the setpoint
// assumes TICK_CYCLES is shortened to 4 so one dwell tick lasts 4 cycles
`timescale 1ns/1ps
module list_waveform_sequencer_bench;
  import list_seq_pkg::*;
  localparam int TICKS = 4;
  localparam int STEP  = 2 * TICKS; // every step dwells two ticks
  logic                  aclk, aresetn, awready, wready, bvalid, bready, arready, rvalid;
  logic                  rready, awvalid, wvalid, arvalid, output_on, running, hung;
  logic [ADDR_W-1:0]     awaddr, araddr;
  logic [DATA_W-1:0]     wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic [LEVEL_W-1:0]    setpoint;
  int                    n_mismatch, total_checks;

  list_sequencer #(.TICK_CYCLES(TICKS)) list_sequencer_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .setpoint, .output_on, .running);
  list_host list_host_inst (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hung);

  // clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // register write with expected response
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    list_host_inst.wr(a, d, r);
    check({30'h0, r}, {30'h0, er}, "write response");
  endtask
  // register read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    list_host_inst.rd(a, d, r);
    check(d, ed, "read data");
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask
  // follow a run started by the last write: one sample in the middle of every step
  task automatic play(input logic [15:0] q[$]);
    repeat (3) @(posedge aclk);
    foreach (q[i]) begin
      #1;
      check({16'h0, setpoint}, {16'h0, q[i]}, "step level");
      check({31'h0, running}, 32'h1, "running in step");
      repeat (STEP) @(posedge aclk);
    end
    #1;
    check({31'h0, running}, 32'h0, "stopped after last pass");
    check({16'h0, setpoint}, {16'h0, q[q.size()-1]}, "held level");
  endtask
  // a stalled bus ends the run
  always @(posedge hung) begin
    n_mismatch++;
    complete_run();
  end

  initial begin
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    check({15'h0, setpoint, running}, 32'h0, "reset outputs");
    rd(OFS_LEVEL_POINTS, 32'h0, RESP_OKAY);
    $display("test reset done");
    // load two groups of levels and one dwell, refusing out-of-range dwells
    w(OFS_CTRL, 32'h09, RESP_OKAY);
    for (int i = 1; i <= 3; i++) w(OFS_LEVEL_LOAD, 32'(10 * i), RESP_OKAY);
    rd(OFS_LEVEL_POINTS, 32'h3, RESP_OKAY);
    w(OFS_LEVEL_LOAD, 32'h28, RESP_OKAY);
    w(OFS_LEVEL_LOAD, 32'h32, RESP_OKAY);
    rd(OFS_LEVEL_POINTS, 32'h5, RESP_OKAY);
    w(OFS_DWELL_LOAD, 32'h0, RESP_SLVERR);
    w(OFS_DWELL_LOAD, 32'h4E21, RESP_SLVERR);
    w(OFS_DWELL_LOAD, 32'h2, RESP_OKAY);
    rd(OFS_DWELL_POINTS, 32'h1, RESP_OKAY);
    $display("test loading done");
    // two passes upward, one leading step skipped on the second
    w(OFS_REPEAT_COUNT, 32'h2, RESP_OKAY);
    w(OFS_LEADING_SKIP, 32'h1, RESP_OKAY);
    w(OFS_CTRL, 32'h1A, RESP_OKAY);
    check({31'h0, output_on}, 32'h1, "output on");
    play('{16'h0A, 16'h14, 16'h1E, 16'h28, 16'h32, 16'h14, 16'h1E, 16'h28, 16'h32});
    $display("test upward run done");
    // two passes downward, skip count left set but without effect
    w(OFS_CTRL, 32'h1C, RESP_OKAY);
    w(OFS_CTRL, 32'h1E, RESP_OKAY);
    play('{16'h32, 16'h28, 16'h1E, 16'h14, 16'h0A, 16'h32, 16'h28, 16'h1E, 16'h14, 16'h0A});
    check({16'h0, setpoint}, 32'h0A, "down run end level");
    $display("test downward run done");
    // unmapped read, current mode refusal, clear restores direction and pointers
    rd(8'h40, 32'h0, RESP_SLVERR);
    rd(OFS_CTRL, 32'h1C, RESP_OKAY);
    w(OFS_CTRL, 32'h14, RESP_OKAY);
    w(OFS_LEVEL_LOAD, 32'h46, RESP_SLVERR);
    w(OFS_CTRL, 32'h1D, RESP_OKAY);
    rd(OFS_CTRL, 32'h18, RESP_OKAY);
    rd(OFS_LEVEL_POINTS, 32'h0, RESP_OKAY);
    rd(OFS_LEADING_SKIP, 32'h0, RESP_OKAY);
    rd(OFS_DWELL_POINTS, 32'h0, RESP_OKAY);
    w(OFS_LEVEL_LOAD, 32'h46, RESP_OKAY);
    w(OFS_DWELL_LOAD, 32'h2, RESP_OKAY);
    w(OFS_CTRL, 32'h1A, RESP_OKAY);
    play('{16'h46, 16'h46});
    rd(OFS_STATUS, 32'h0046_0000, RESP_OKAY);
    $display("test clear done");
    complete_run();
  end
endmodule
